// *** rtl/io_cell_pkg.sv ***
// Shared constants and types of the configurable I/O cell
package io_cell_pkg;
   // Modes of the shared set/reset for one storage element
   typedef enum logic [1:0] {
      SR_SYNC_SET = 2'b00,
      SR_SYNC_RST = 2'b01,
      SR_ASYNC_PRE = 2'b10,
      SR_ASYNC_CLR = 2'b11
   } sr_mode_t;

   // Bit positions in the polarity inversion vector
   localparam int POL_W = 7;
   localparam int POL_CLK = 0;
   localparam int POL_CE_IN = 1;
   localparam int POL_CE_OUT = 2;
   localparam int POL_CE_OE = 3;
   localparam int POL_SR = 4;
   localparam int POL_TRI = 5;
   localparam int POL_OUT = 6;

   // Stages the cell clock spends in its distribution path
   localparam int CLK_DIST_STAGES = 1;

   // Reset values
   localparam logic RST_LOW = 1'b0;
   localparam logic RST_HIGH = 1'b1;
endpackage : io_cell_pkg

// *** rtl/io_store.sv ***
// One storage element of the I/O cell: flip-flop or latch with set/reset
`timescale 1ns/10ps
module io_store
   import io_cell_pkg::*;
(
   input wire logic clock, // System clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic d, // Data in
   input wire logic ce, // Clock enable, polarity already applied
   input wire logic clk_edge, // Rising edge of the cell clock
   input wire logic clk_level, // Cell clock level, for latch mode
   input wire logic sr, // Shared set/reset, polarity already applied
   input wire logic latch_mode, // 1 latch, 0 flip-flop
   input wire sr_mode_t sr_mode, // How sr acts on this element
   output logic q // Stored value
);
   logic q_ff;
   logic nxt_q;
   wire load = latch_mode ? clk_level : clk_edge; // see (R1)
   wire async_mode = (sr_mode == SR_ASYNC_PRE) || (sr_mode == SR_ASYNC_CLR);
   wire sr_value = (sr_mode == SR_SYNC_SET) || (sr_mode == SR_ASYNC_PRE);

   // Async modes act at once; sync modes wait for the element to load
   always_comb begin
      nxt_q = q_ff;
      if (sr && async_mode) begin // see (R3)
         nxt_q = sr_value;
      end else if (load && sr) begin // see (R3)
         nxt_q = sr_value;
      end else if (load && ce) begin // see (R2)
         nxt_q = d;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         q_ff <= RST_LOW;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign q = q_ff;

   property p_async_acts;
      @(posedge clock) disable iff (rst)
      (sr && async_mode) |=> (q == $past(sr_value));
   endproperty
   a_async_acts: assert property (p_async_acts) // see (R3)
      else $error("async set/reset did not act");

   property p_flop_holds;
      @(posedge clock) disable iff (rst)
      (!latch_mode && !clk_edge && !(sr && async_mode)) |=> $stable(q);
   endproperty
   a_flop_holds: assert property (p_flop_holds) // see (R1)
      else $error("flip-flop changed without a clock edge");

   property p_latch_follows;
      @(posedge clock) disable iff (rst)
      (latch_mode && clk_level && ce && !sr) |=> (q == $past(d));
   endproperty
   a_latch_follows: assert property (p_latch_follows) // see (R1)
      else $error("transparent latch did not follow data");

   property p_ce_gates;
      @(posedge clock) disable iff (rst)
      (!ce && !sr) |=> $stable(q);
   endproperty
   a_ce_gates: assert property (p_ce_gates) // see (R2)
      else $error("element loaded with enable low");
endmodule : io_store

// *** rtl/io_cell.sv ***
// Configurable I/O cell between user logic and one package pad
// Summary of operation
// (R1) Each of the three storage elements works as an edge flip-flop or a transparent latch.
// (R2) One cell clock feeds all three elements, each with its own clock enable.
// (R3) One shared set/reset acts per element as sync set, sync reset, async preset or clear.
// (R4) The output driver and each control input have their own polarity inversion.
// (R5) Before configuration the pad is not driven and pull-down and keeper stay off.
// (R6) A global mode pin picks pull-ups before configuration, otherwise the pad floats.
// (R7) The pad input reaches user logic direct, through the input element, or both.
// (R8) An optional delay matched to the clock path sits before the input element.
// (R9) Pad data comes direct from user logic or from the output element.
// (R10) The three-state control comes direct from user logic or from its element.
// (R11) Pull-up, pull-down and keeper are each selectable after configuration.
// (R12) The keeper weakly holds the pad at the last level seen on its input.
// (R13) The cell joins a boundary scan chain to observe and control its pad.
// (R14) All routing, mode, polarity and pull selections are static configuration.
`timescale 1ns/10ps
module io_cell
   import io_cell_pkg::*;
#(
   parameter int IN_DLY_STAGES = CLK_DIST_STAGES // Stages of the input delay
)
(
   input wire logic clock, // System clock, 50 MHz
   input wire logic rst, // Synchronous reset, active high
   input wire logic cfg_done, // Configuration has completed
   input wire logic pre_cfg_pullup, // Mode pin: pull-ups before configuration
   input wire logic [POL_W-1:0] pol_inv, // Polarity inversion per control
   input wire logic [2:0] latch_mode, // Per element: 1 latch (in, out, oe)
   input wire sr_mode_t sr_mode_in, // Set/reset mode of input element
   input wire sr_mode_t sr_mode_out, // Set/reset mode of output element
   input wire sr_mode_t sr_mode_oe, // Set/reset mode of enable element
   input wire logic in_dly_en, // Insert delay before input element
   input wire logic out_reg_sel, // Pad data from output element
   input wire logic oe_reg_sel, // Three-state control from its element
   input wire logic pull_up_sel, // Pull-up after configuration
   input wire logic pull_down_sel, // Pull-down after configuration
   input wire logic keeper_sel, // Keeper after configuration
   input wire logic cell_clk, // Cell clock from user logic
   input wire logic ce_in, // Clock enable, input element
   input wire logic ce_out, // Clock enable, output element
   input wire logic ce_oe, // Clock enable, enable element
   input wire logic shared_set_reset, // Shared set/reset
   input wire logic out_data, // Data to drive on the pad
   input wire logic tri_ctl, // Three-state control, 1 floats the pad
   output logic in_direct, // Pad level, registered one clock, bypassing the input element
   output logic in_reg, // Pad level from input element
   input wire logic pad_in, // Pad level seen by the input buffer
   output logic pad_out, // Level driven on the pad
   output logic pad_oe_n, // Pad driver enable, low drives
   output logic pull_up_en, // Weak pull-up on
   output logic pull_down_en, // Weak pull-down on
   output logic keeper_en, // Weak keeper on
   output logic keeper_level, // Level the keeper holds
   input wire logic bs_tdi, // Scan data in
   input wire logic bs_capture, // Scan capture strobe
   input wire logic bs_shift, // Scan shift strobe
   input wire logic bs_update, // Scan update strobe
   input wire logic bs_extest, // Scan cells control the pad
   output logic bs_tdo // Scan data out
);
   // Refuse a delay line shorter than the clock path it has to match
   if (IN_DLY_STAGES < 1) begin : g_bad_dly
      $error("IN_DLY_STAGES must be at least 1");
   end

   logic clk_s_ff, clk_d_ff;
   logic [IN_DLY_STAGES-1:0] dly_ff;
   logic in_direct_ff, pad_out_ff, pad_oe_n_ff;
   logic pull_up_ff, pull_down_ff, keeper_en_ff, keeper_level_ff;
   logic bs_in_ff, bs_out_ff, bs_oe_ff, bs_upd_out_ff, bs_upd_oe_ff;
   logic in_q, out_q, oe_q;
   logic nxt_pad_out, nxt_pad_oe_n;

   // Polarity-corrected controls
   wire clk_pol = cell_clk ^ pol_inv[POL_CLK]; // see (R4) (R14)
   wire ce_in_pol = ce_in ^ pol_inv[POL_CE_IN]; // see (R4)
   wire ce_out_pol = ce_out ^ pol_inv[POL_CE_OUT]; // see (R4)
   wire ce_oe_pol = ce_oe ^ pol_inv[POL_CE_OE]; // see (R4)
   wire sr_pol = shared_set_reset ^ pol_inv[POL_SR]; // see (R4)
   wire tri_pol = tri_ctl ^ pol_inv[POL_TRI]; // see (R4)

   // Cell clock passes one distribution stage before edge detection
   wire clk_edge = clk_s_ff & ~clk_d_ff; // see (R2)
   wire clk_level = clk_s_ff;

   // Delay line matched to the clock path so hold at the pad is zero
   wire in_d = in_dly_en ? dly_ff[IN_DLY_STAGES-1] : pad_in; // see (R8)
   wire [IN_DLY_STAGES:0] dly_shift = {dly_ff, pad_in};

   // Core view of data and float control before the scan override
   wire core_out = (out_reg_sel ? out_q : out_data) ^ pol_inv[POL_OUT]; // see (R9) (R4)
   wire core_float = oe_reg_sel ? oe_q : tri_pol; // see (R10)

   assign nxt_pad_out = bs_extest ? bs_upd_out_ff : core_out; // see (R13)
   // Pad floats until configuration is done
   assign nxt_pad_oe_n = !cfg_done || (bs_extest ? bs_upd_oe_ff : core_float); // see (R5)

   io_store u_in_store (
      .clock(clock), .rst(rst), .d(in_d), .ce(ce_in_pol), .clk_edge(clk_edge),
      .clk_level(clk_level), .sr(sr_pol), .latch_mode(latch_mode[0]),
      .sr_mode(sr_mode_in), .q(in_q)
   ); // see (R7)
   io_store u_out_store (
      .clock(clock), .rst(rst), .d(out_data), .ce(ce_out_pol), .clk_edge(clk_edge),
      .clk_level(clk_level), .sr(sr_pol), .latch_mode(latch_mode[1]),
      .sr_mode(sr_mode_out), .q(out_q)
   );
   io_store u_oe_store (
      .clock(clock), .rst(rst), .d(tri_pol), .ce(ce_oe_pol), .clk_edge(clk_edge),
      .clk_level(clk_level), .sr(sr_pol), .latch_mode(latch_mode[2]),
      .sr_mode(sr_mode_oe), .q(oe_q)
   );

   always_ff @(posedge clock) begin
      if (rst) begin
         // Start from the clock's present corrected level so release gives no false edge
         clk_s_ff <= clk_pol;
         clk_d_ff <= clk_pol;
         dly_ff <= '0;
      end else begin
         clk_s_ff <= clk_pol;
         clk_d_ff <= clk_s_ff;
         dly_ff <= dly_shift[IN_DLY_STAGES-1:0]; // see (R8)
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         in_direct_ff <= RST_LOW;
         pad_out_ff <= RST_LOW;
         pad_oe_n_ff <= RST_HIGH;
      end else begin
         in_direct_ff <= pad_in; // see (R7)
         pad_out_ff <= nxt_pad_out;
         pad_oe_n_ff <= nxt_pad_oe_n;
      end
   end

   // Weak pad functions; pull-down and keeper stay off before configuration
   always_ff @(posedge clock) begin
      if (rst) begin
         pull_up_ff <= RST_LOW;
         pull_down_ff <= RST_LOW;
         keeper_en_ff <= RST_LOW;
      end else begin
         pull_up_ff <= cfg_done ? pull_up_sel : pre_cfg_pullup; // see (R6) (R11)
         pull_down_ff <= cfg_done && pull_down_sel; // see (R5) (R11)
         keeper_en_ff <= cfg_done && keeper_sel; // see (R5) (R11)
      end
   end

   // Keeper tracks the pad level it observes
   always_ff @(posedge clock) begin
      if (rst) begin
         keeper_level_ff <= RST_LOW;
      end else if (keeper_sel) begin
         keeper_level_ff <= pad_in; // see (R12)
      end
   end

   // Scan chain: tdi -> input cell -> output cell -> enable cell -> tdo
   always_ff @(posedge clock) begin
      if (rst) begin
         bs_in_ff <= RST_LOW;
         bs_out_ff <= RST_LOW;
         bs_oe_ff <= RST_HIGH;
      end else if (bs_capture) begin
         bs_in_ff <= pad_in; // see (R13)
         bs_out_ff <= core_out;
         bs_oe_ff <= core_float;
      end else if (bs_shift) begin
         bs_in_ff <= bs_tdi; // see (R13)
         bs_out_ff <= bs_in_ff;
         bs_oe_ff <= bs_out_ff;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         bs_upd_out_ff <= RST_LOW;
         bs_upd_oe_ff <= RST_HIGH;
      end else if (bs_update) begin
         bs_upd_out_ff <= bs_out_ff; // see (R13)
         bs_upd_oe_ff <= bs_oe_ff;
      end
   end

   assign in_direct = in_direct_ff;
   assign in_reg = in_q;
   assign pad_out = pad_out_ff;
   assign pad_oe_n = pad_oe_n_ff;
   assign pull_up_en = pull_up_ff;
   assign pull_down_en = pull_down_ff;
   assign keeper_en = keeper_en_ff;
   assign keeper_level = keeper_level_ff;
   assign bs_tdo = bs_oe_ff;

   property p_pre_cfg_float;
      @(posedge clock) disable iff (rst)
      !cfg_done |=> (pad_oe_n && !pull_down_en && !keeper_en);
   endproperty
   a_pre_cfg_float: assert property (p_pre_cfg_float) // see (R5)
      else $error("pad active before configuration");

   property p_pre_cfg_pullup;
      @(posedge clock) disable iff (rst)
      !cfg_done |=> (pull_up_en == $past(pre_cfg_pullup));
   endproperty
   a_pre_cfg_pullup: assert property (p_pre_cfg_pullup) // see (R6)
      else $error("pull-up does not follow mode pin");

   property p_direct_in;
      @(posedge clock) disable iff (rst)
      1'b1 |=> (in_direct == $past(pad_in));
   endproperty
   a_direct_in: assert property (p_direct_in) // see (R7)
      else $error("direct input path wrong");

   property p_direct_out;
      @(posedge clock) disable iff (rst)
      (!bs_extest && !out_reg_sel) |=> (pad_out == $past(out_data ^ pol_inv[POL_OUT]));
   endproperty
   a_direct_out: assert property (p_direct_out) // see (R9)
      else $error("direct output path wrong");

   property p_reg_oe;
      @(posedge clock) disable iff (rst)
      (cfg_done && !bs_extest && oe_reg_sel) |=> (pad_oe_n == $past(oe_q));
   endproperty
   a_reg_oe: assert property (p_reg_oe) // see (R10)
      else $error("registered enable path wrong");

   property p_keeper;
      @(posedge clock) disable iff (rst)
      keeper_sel ##1 keeper_sel |-> (keeper_level == $past(pad_in));
   endproperty
   a_keeper: assert property (p_keeper) // see (R12)
      else $error("keeper lost the pad level");

   property p_dly_match;
      @(posedge clock) disable iff (rst)
      (in_dly_en && IN_DLY_STAGES == CLK_DIST_STAGES) |-> (in_d == $past(pad_in));
   endproperty
   a_dly_match: assert property (p_dly_match) // see (R8)
      else $error("input delay does not match clock path");

   property p_scan_shift;
      @(posedge clock) disable iff (rst)
      (bs_shift && !bs_capture) |=> (bs_tdo == $past(bs_out_ff));
   endproperty
   a_scan_shift: assert property (p_scan_shift) // see (R13)
      else $error("scan chain did not shift");
endmodule : io_cell

// *** testbench/pad_board_model.sv ***
// Board side of the pad: external driver, weak pulls and keeper
`timescale 1ns/10ps
module pad_board_model (
   input wire logic clock, // System clock
   input wire logic board_drive, // Board drives the pad
   input wire logic board_val, // Level the board drives
   input wire logic pad_out, // Cell output level
   input wire logic pad_oe_n, // Cell driver enable, low drives
   input wire logic pull_up_en, // Weak pull-up
   input wire logic pull_down_en, // Weak pull-down
   input wire logic keeper_en, // Weak keeper
   input wire logic keeper_level, // Keeper level
   output logic pad_in // Resolved pad level
);
   logic float_ff = 1'b0;
   // A floating pad shows a changing level, never a settled guess
   always_ff @(posedge clock) begin
      float_ff <= !float_ff;
   end
   assign pad_in = !pad_oe_n ? pad_out : board_drive ? board_val : pull_up_en ? 1'b1 :
      pull_down_en ? 1'b0 : keeper_en ? keeper_level : float_ff;
endmodule : pad_board_model

// *** testbench/configurable_io_cell_tb.sv ***
// Self-checking bench of the configurable I/O cell
`timescale 1ns/10ps
module configurable_io_cell_tb;
   import io_cell_pkg::*;
   logic clock, rst, cfg_done, pre_cfg_pullup, in_dly_en, out_reg_sel, oe_reg_sel;
   logic pull_up_sel, pull_down_sel, keeper_sel, cell_clk, ce_in, ce_out, ce_oe;
   logic shared_set_reset, out_data, tri_ctl, bs_tdi, bs_capture, bs_shift, bs_update;
   logic bs_extest, board_drive, board_val, in_direct, in_reg, pad_in, pad_out, pad_oe_n;
   logic pull_up_en, pull_down_en, keeper_en, keeper_level, bs_tdo, eo, et, v;
   logic [POL_W-1:0] pol_inv;
   logic [2:0] latch_mode;
   logic [31:0] r;
   sr_mode_t sr_mode_in, sr_mode_out, sr_mode_oe;
   int failures, comparisons, i, seed;

   io_cell dut (.clock, .rst, .cfg_done, .pre_cfg_pullup, .pol_inv, .latch_mode, .sr_mode_in,
      .sr_mode_out, .sr_mode_oe, .in_dly_en, .out_reg_sel, .oe_reg_sel, .pull_up_sel,
      .pull_down_sel, .keeper_sel, .cell_clk, .ce_in, .ce_out, .ce_oe, .shared_set_reset,
      .out_data, .tri_ctl, .in_direct, .in_reg, .pad_in, .pad_out, .pad_oe_n, .pull_up_en,
      .pull_down_en, .keeper_en, .keeper_level, .bs_tdi, .bs_capture, .bs_shift, .bs_update,
      .bs_extest, .bs_tdo);
   pad_board_model board (.clock, .board_drive, .board_val, .pad_out, .pad_oe_n, .pull_up_en,
      .pull_down_en, .keeper_en, .keeper_level, .pad_in);

   function automatic logic sr_level(input sr_mode_t m);
      return (m == SR_SYNC_SET) || (m == SR_ASYNC_PRE);
   endfunction : sr_level
   function automatic logic pad_level(input logic fl, input logic d, input logic b);
      return fl ? b : d;
   endfunction : pad_level
   task automatic check(input logic seen, input logic exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %b expected %b", $time, seen, exp);
      end
   endtask : check
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : step
   // One rise and fall of the cell clock, in its configured sense
   task automatic cell_pulse();
      cell_clk = !pol_inv[POL_CLK];
      step(2);
      cell_clk = pol_inv[POL_CLK];
      step(3);
   endtask : cell_pulse
   task automatic end_sim();
      $display("Comparisons %0d, failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim

   initial begin
      clock = 1'b0;
      forever #10 clock = !clock;
   end
   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      end_sim();
   end

   initial begin
      {cfg_done, pre_cfg_pullup, in_dly_en, out_reg_sel, oe_reg_sel, pull_up_sel} = '0;
      {pull_down_sel, keeper_sel, cell_clk, ce_in, ce_out, ce_oe, shared_set_reset} = '0;
      {out_data, tri_ctl, bs_tdi, bs_capture, bs_shift, bs_update, bs_extest} = '0;
      {board_drive, board_val, pol_inv, latch_mode} = '0;
      sr_mode_in = SR_SYNC_SET;
      sr_mode_out = SR_SYNC_RST;
      sr_mode_oe = SR_ASYNC_CLR;
      failures = 0;
      comparisons = 0;
      seed = 32'hD44A;
      rst = 1'b1;
      step(5);
      rst = 1'b0;
      check(pad_oe_n, 1'b1);
      check(pad_out, 1'b0);
      check(in_reg, 1'b0);
      check(bs_tdo, 1'b1);
      {pull_down_sel, keeper_sel} = 2'h3;
      for (i = 0; i < 2; i++) begin
         pre_cfg_pullup = i[0];
         step(2);
         check(pad_oe_n, 1'b1);
         check(pull_up_en, i[0]);
         check(pull_down_en, 1'b0);
         check(keeper_en, 1'b0);
      end
      cfg_done = 1'b1;
      for (i = 0; i < 16; i++) begin
         r = $random(seed);
         {pol_inv[POL_OUT], pol_inv[POL_TRI], out_data, tri_ctl} = r[3:0];
         {pull_up_sel, pull_down_sel, keeper_sel} = r[6:4];
         // Cell floats when the corrected three-state control is high
         v = r[2] ^ r[0];
         board_drive = v;
         board_val = r[7];
         step(2);
         check(pad_oe_n, !cfg_done | v);
         check(pad_out, r[1] ^ r[3]);
         check(pull_up_en, r[6]);
         check(pull_down_en, r[5]);
         check(keeper_en, r[4]);
         check(in_direct, pad_level(v, r[1] ^ r[3], r[7]));
      end
      {board_drive, pull_up_sel, pull_down_sel, keeper_sel, out_reg_sel, oe_reg_sel} = 6'h03;
      pol_inv = '0;
      {eo, et} = 2'h0;
      for (i = 0; i < 10; i++) begin
         r = $random(seed);
         {pol_inv[POL_CLK], pol_inv[POL_CE_OUT], pol_inv[POL_CE_OE], pol_inv[POL_SR]} = r[3:0];
         {cell_clk, shared_set_reset} = {r[3], r[0]};
         ce_out = (r[4] | i < 2) ^ r[2];
         ce_oe = r[5] ^ r[1];
         {out_data, tri_ctl} = r[7:6];
         if (r[4] | i < 2) eo = r[7];
         if (r[5]) et = r[6];
         cell_pulse();
         check(pad_out, eo);
         check(pad_oe_n, et);
      end
      {oe_reg_sel, tri_ctl, board_drive, pol_inv} = '0;
      tri_ctl = 1'b1;
      board_drive = 1'b1;
      cell_clk = 1'b0;
      shared_set_reset = 1'b0;
      // Let the cell release the pad before the input element is probed
      step(2);
      for (i = 0; i < 4; i++) begin
         r = $random(seed);
         sr_mode_in = sr_mode_t'(i[1:0]);
         {pol_inv[POL_CE_IN], pol_inv[POL_SR], in_dly_en} = r[2:0];
         shared_set_reset = r[1];
         board_val = !sr_level(sr_mode_in);
         ce_in = !r[2];
         cell_pulse();
         check(in_reg, board_val);
         check(in_direct, board_val);
         ce_in = r[2];
         shared_set_reset = !r[1];
         if (i < 2) cell_pulse();
         else step(3);
         check(in_reg, sr_level(sr_mode_in));
         shared_set_reset = r[1];
      end
      {pol_inv, ce_in} = 8'h01;
      shared_set_reset = 1'b0;
      for (i = 0; i < 2; i++) begin
         in_dly_en = i[0];
         board_val = 1'b0;
         cell_clk = 1'b1;
         step(1);
         board_val = 1'b1;
         step(1);
         check(in_reg, !in_dly_en);
         cell_clk = 1'b0;
         step(3);
      end
      // A latch follows data while the clock is high; a flip-flop does not
      latch_mode = 3'h1;
      cell_clk = 1'b1;
      board_val = 1'b0;
      step(4);
      check(in_reg, 1'b0);
      board_val = 1'b1;
      step(3);
      check(in_reg, 1'b1);
      latch_mode = 3'h0;
      board_val = 1'b0;
      step(4);
      check(in_reg, 1'b1);
      cell_clk = 1'b0;
      board_drive = 1'b0;
      keeper_sel = 1'b1;
      for (i = 0; i < 2; i++) begin
         board_drive = 1'b1;
         board_val = i[0];
         step(3);
         board_drive = 1'b0;
         step(4);
         check(in_direct, i[0]);
         check(keeper_level, i[0]);
      end
      r = $random(seed);
      v = r[0];
      bs_shift = 1'b1;
      for (i = 0; i < 3; i++) begin
         bs_tdi = (i == 1) ? v : 1'b0;
         step(1);
      end
      bs_shift = 1'b0;
      check(bs_tdo, 1'b0);
      bs_update = 1'b1;
      step(1);
      bs_update = 1'b0;
      bs_extest = 1'b1;
      step(3);
      check(pad_oe_n, 1'b0);
      check(pad_out, v);
      // Capture the pad level and core float, then shift the pad bit out
      bs_capture = 1'b1;
      step(1);
      bs_capture = 1'b0;
      check(bs_tdo, 1'b1);
      bs_shift = 1'b1;
      step(2);
      bs_shift = 1'b0;
      check(bs_tdo, v);
      end_sim();
   end
endmodule : configurable_io_cell_tb
